// ---- include/wdt_pkg.sv ----
package wdt_pkg;
  // ****************************************
  // counter and prescaler
  // ****************************************
  localparam int          CNT_W          = 14;
  localparam int          PRE_W          = 8;
  localparam logic [13:0] CNT_RESET_VAL  = 14'h3FFF;
  localparam logic [7:0]  REFRESH_FIRST  = 8'h00;
  localparam logic [7:0]  REFRESH_SECOND = 8'hFF;
  // prescale_select codes, other codes fall back to divide by 1
  localparam logic [3:0]  PRE_DIV1   = 4'h0;
  localparam logic [3:0]  PRE_DIV16  = 4'h2;
  localparam logic [3:0]  PRE_DIV32  = 4'h3;
  localparam logic [3:0]  PRE_DIV64  = 4'h4;
  localparam logic [3:0]  PRE_DIV128 = 4'hF;
  localparam logic [3:0]  PRE_DIV256 = 4'h5;
  // timeout_select: starting counts
  localparam logic [13:0] TOUT_0 = 14'h03FF;
  localparam logic [13:0] TOUT_1 = 14'h0FFF;
  localparam logic [13:0] TOUT_2 = 14'h1FFF;
  localparam logic [13:0] TOUT_3 = 14'h3FFF;
  // fault action
  localparam logic        ACT_NMI = 1'b1;
endpackage : wdt_pkg

// ---- design/wdt_prescaler.sv ----
`timescale 1ns/1ns
module wdt_prescaler
  import wdt_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       src_tick,
  input  wire logic       restart,
  input  wire logic [3:0] prescale_select,
  output logic            tick
);
  logic [PRE_W-1:0] div_reg;
  logic [PRE_W-1:0] mask;
  // ****************************************
  // ratio decode
  // ****************************************
  assign mask = (prescale_select == PRE_DIV16)  ? 8'h0F :
                (prescale_select == PRE_DIV32)  ? 8'h1F :
                (prescale_select == PRE_DIV64)  ? 8'h3F :
                (prescale_select == PRE_DIV128) ? 8'h7F :
                (prescale_select == PRE_DIV256) ? 8'hFF : 8'h00;
  assign tick = src_tick && ((div_reg & mask) == mask);
  always_ff @(posedge sys_clk) begin
    if (sys_rst || restart) begin
      div_reg <= 8'h00;
    end else if (src_tick) begin
      div_reg <= div_reg + 8'h01;
    end
  end
endmodule : wdt_prescaler

// ---- design/wdt_core.sv ----
`timescale 1ns/1ns
module wdt_core
  import wdt_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        watchdog_private_clock,
  input  wire logic        auto_start,
  input  wire logic [3:0]  opt_prescale_select,
  input  wire logic [1:0]  opt_timeout_select,
  input  wire logic [1:0]  opt_window_open_select,
  input  wire logic [1:0]  opt_window_close_select,
  input  wire logic        opt_fault_action_select,
  input  wire logic        opt_lowpower_count_halt,
  input  wire logic [3:0]  prescale_select,
  input  wire logic [1:0]  timeout_select,
  input  wire logic [1:0]  window_open_select,
  input  wire logic [1:0]  window_close_select,
  input  wire logic        fault_action_select,
  input  wire logic        lowpower_count_halt,
  input  wire logic        lowpower_state,
  input  wire logic        refresh_write,
  input  wire logic [7:0]  refresh_data,
  output logic [13:0]      count_status_register,
  output logic             reset_request,
  output logic             nmi_request,
  output logic             sleep_halt_ctrl,
  output logic             underflow_event,
  output logic             refresh_error_event,
  output logic             counting
);
  // ****************************************
  // private clock sync and edge
  // ****************************************
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic src_tick;
  always_ff @(posedge sys_clk) begin
    sync1_reg <= watchdog_private_clock;
    sync2_reg <= sync1_reg;
    sync3_reg <= sync2_reg;
  end
  assign src_tick = sync2_reg && !sync3_reg;

  // ****************************************
  // configuration select
  // ****************************************
  logic [3:0]  act_pre_reg;
  logic [3:0]  sel_pre;
  logic [1:0]  sel_tout;
  logic [1:0]  sel_wopen;
  logic [1:0]  sel_wclose;
  logic        sel_nmi;
  logic        sel_halt;
  logic [13:0] reload_val;
  logic [13:0] quarter;
  logic [13:0] win_hi;
  logic [13:0] win_lo;
  assign sel_pre    = auto_start ? opt_prescale_select : act_pre_reg;
  assign sel_tout   = auto_start ? opt_timeout_select : timeout_select;
  assign sel_wopen  = auto_start ? opt_window_open_select : window_open_select;
  assign sel_wclose = auto_start ? opt_window_close_select : window_close_select;
  assign sel_nmi    = auto_start ? opt_fault_action_select : fault_action_select;
  assign sel_halt   = auto_start ? opt_lowpower_count_halt : lowpower_count_halt;
  assign reload_val = (sel_tout == 2'h0) ? TOUT_0 :
                      (sel_tout == 2'h1) ? TOUT_1 :
                      (sel_tout == 2'h2) ? TOUT_2 : TOUT_3;
  // window positions for codes 0..3 at 25/50/75/100 percent (open) and 75/50/25/0 (close)
  // widened by one bit so the largest timeout does not wrap to a zero quarter
  assign quarter = 14'(({1'b0, reload_val} + 15'h0001) >> 2);
  assign win_hi  = 14'(reload_val - 14'(quarter * (14'(sel_wopen) ^ 14'h0003)));
  assign win_lo  = 14'(quarter * 14'(sel_wclose ^ 2'h3));

  // ****************************************
  // refresh sequence
  // ****************************************
  logic [13:0] cnt_reg;
  logic        counting_reg;
  logic armed_reg;
  logic refresh_ok;
  logic in_window;
  logic refresh_good;
  logic refresh_bad;
  assign refresh_ok   = refresh_write && armed_reg && (refresh_data == REFRESH_SECOND);
  assign in_window    = (cnt_reg <= win_hi) && (cnt_reg >= win_lo);
  assign refresh_good = refresh_ok && (!counting_reg || in_window);
  assign refresh_bad  = refresh_ok && counting_reg && !in_window;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      armed_reg <= 1'b0;
    end else if (refresh_write) begin
      armed_reg <= (refresh_data == REFRESH_FIRST);
    end
  end

  // ****************************************
  // counter
  // ****************************************
  logic        started_reg;
  logic        tick;
  logic        halted;
  logic        underflow;
  logic        fault;
  assign halted    = sel_halt && lowpower_state;
  assign underflow = counting_reg && !halted && tick && (cnt_reg == 14'h0000);
  assign fault     = underflow || refresh_bad;

  wdt_prescaler u_pre (
    .sys_clk         (sys_clk),
    .sys_rst         (sys_rst),
    .src_tick        (src_tick && counting_reg && !halted),
    .restart         (refresh_good || fault),
    .prescale_select (sel_pre),
    .tick            (tick)
  );

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_reg      <= CNT_RESET_VAL;
      counting_reg <= 1'b0;
      started_reg  <= 1'b0;
      act_pre_reg  <= PRE_DIV1;
    end else if (auto_start && !started_reg) begin
      cnt_reg      <= reload_val;
      counting_reg <= 1'b1;
      started_reg  <= 1'b1;
    end else if (fault) begin
      cnt_reg      <= reload_val;
      counting_reg <= auto_start;
    end else if (refresh_good) begin
      cnt_reg      <= reload_val;
      counting_reg <= 1'b1;
      act_pre_reg  <= prescale_select;
    end else if (counting_reg && !halted && tick) begin
      cnt_reg <= cnt_reg - 14'h0001;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      count_status_register <= CNT_RESET_VAL;
      reset_request         <= 1'b0;
      nmi_request           <= 1'b0;
      sleep_halt_ctrl       <= 1'b0;
      underflow_event       <= 1'b0;
      refresh_error_event   <= 1'b0;
      counting              <= 1'b0;
    end else begin
      count_status_register <= cnt_reg;
      reset_request         <= fault && (sel_nmi != ACT_NMI);
      nmi_request           <= fault && (sel_nmi == ACT_NMI);
      sleep_halt_ctrl       <= sel_halt;
      underflow_event       <= underflow;
      refresh_error_event   <= refresh_bad;
      counting              <= counting_reg;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_fault_nmi;
    @(posedge sys_clk) disable iff (sys_rst)
      (fault && sel_nmi == ACT_NMI) |=> nmi_request && !reset_request;
  endproperty
  a_fault_nmi: assert property (p_fault_nmi) else $error("nmi not raised");
  property p_sw_stop;
    @(posedge sys_clk) disable iff (sys_rst)
      (fault && !auto_start) |=> !counting_reg;
  endproperty
  a_sw_stop: assert property (p_sw_stop) else $error("counter kept running");
  property p_reload;
    @(posedge sys_clk) disable iff (sys_rst)
      (refresh_good && !fault && !(auto_start && !started_reg)) |=> cnt_reg == $past(reload_val);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload");
  sequence s_arm_write;
    refresh_write && (refresh_data == REFRESH_FIRST);
  endsequence
  sequence s_other_write;
    refresh_write && (refresh_data != REFRESH_FIRST);
  endsequence
  property p_bad_seq;
    @(posedge sys_clk) disable iff (sys_rst)
      s_arm_write ##1 s_other_write |=> !armed_reg;
  endproperty
  a_bad_seq: assert property (p_bad_seq) else $error("bad refresh accepted");
  property p_halt;
    @(posedge sys_clk) disable iff (sys_rst)
      (halted && !fault && !refresh_good && !(auto_start && !started_reg)) |=> $stable(cnt_reg);
  endproperty
  a_halt: assert property (p_halt) else $error("count moved while halted");
  property p_status;
    @(posedge sys_clk) disable iff (sys_rst)
      1'b1 |=> count_status_register == $past(cnt_reg);
  endproperty
  a_status: assert property (p_status) else $error("status stale");
  property p_auto;
    @(posedge sys_clk) (sys_rst && auto_start) ##1 (!sys_rst && auto_start)[*2] |-> counting_reg;
  endproperty
  a_auto: assert property (p_auto) else $error("auto start missing");
  property p_err_evt;
    @(posedge sys_clk) disable iff (sys_rst)
      (refresh_bad && !underflow) |=> refresh_error_event && !underflow_event;
  endproperty
  a_err_evt: assert property (p_err_evt) else $error("refresh error event missing");
endmodule : wdt_core

// ---- testbench/tb.sv ----
`timescale 1ns/1ns
module tb
  import wdt_pkg::*;
;
  // ****************************************
  // stimulus and observation
  // ****************************************
  logic        sys_clk = 0, sys_rst = 1, pclk = 0, auto_start = 0, clr = 0;
  logic [3:0]  opt_pre = PRE_DIV1, pre = PRE_DIV1;
  logic [1:0]  opt_tout = 2'h0, opt_open = 2'h3, opt_close = 2'h3;
  logic [1:0]  tout = 2'h0, wopen = 2'h3, wclose = 2'h3;
  logic        opt_act = ACT_NMI, act = ACT_NMI, opt_halt = 0, halt = 0, lp = 0;
  logic        rw = 0;
  logic [7:0]  rd = 8'h00;
  logic [13:0] status;
  logic        rst_req, nmi, halt_ctrl, uf_ev, err_ev, counting;
  logic [3:0]  seen = 4'h0;
  int          mismatches = 0, n_compared = 0, cycles = 0;

  wdt_core u_wdt_core (.sys_clk(sys_clk), .sys_rst(sys_rst), .watchdog_private_clock(pclk),
    .auto_start(auto_start), .opt_prescale_select(opt_pre), .opt_timeout_select(opt_tout),
    .opt_window_open_select(opt_open), .opt_window_close_select(opt_close),
    .opt_fault_action_select(opt_act), .opt_lowpower_count_halt(opt_halt),
    .prescale_select(pre), .timeout_select(tout), .window_open_select(wopen),
    .window_close_select(wclose), .fault_action_select(act), .lowpower_count_halt(halt),
    .lowpower_state(lp), .refresh_write(rw), .refresh_data(rd),
    .count_status_register(status), .reset_request(rst_req), .nmi_request(nmi),
    .sleep_halt_ctrl(halt_ctrl), .underflow_event(uf_ev), .refresh_error_event(err_ev),
    .counting(counting));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // one-cycle pulses are caught here so a slow check cannot miss them
  always @(posedge sys_clk) begin
    seen <= clr ? 4'h0 : (seen | {uf_ev, err_ev, nmi, rst_req});
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask : chk

  task automatic settle();
    repeat (8) @(posedge sys_clk);
  endtask : settle

  // slow private clock edges, wide enough for the two-flop synchroniser
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge sys_clk) pclk <= 1'b1;
      repeat (3) @(posedge sys_clk);
      pclk <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
    settle();
  endtask : pulses

  task automatic refresh(input logic [7:0] b1, input logic [7:0] b2);
    @(posedge sys_clk) rw <= 1'b1;
    rd <= b1;
    @(posedge sys_clk) rd <= b2;
    @(posedge sys_clk) rw <= 1'b0;
    settle();
  endtask : refresh

  task automatic clear_seen();
    @(posedge sys_clk) clr <= 1'b1;
    @(posedge sys_clk) clr <= 1'b0;
  endtask : clear_seen

  task automatic do_reset();
    @(posedge sys_clk) sys_rst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
  endtask : do_reset

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    do_reset();
    settle();
    chk(status, 16'h3FFF);
    chk({nmi, rst_req, counting}, 16'h0);
    pulses(3);
    chk(status, 16'h3FFF);
    refresh(REFRESH_FIRST, REFRESH_SECOND);
    chk(status, TOUT_0);
    chk(counting, 1'b1);
    pulses(5);
    chk(status, 16'h03FA);
    refresh(8'h00, 8'h55);
    refresh(8'h55, 8'hFF);
    chk(status, 16'h03FA);
    halt <= 1'b1;
    lp <= 1'b1;
    pulses(4);
    chk(status, 16'h03FA);
    chk(halt_ctrl, 1'b1);
    halt <= 1'b0;
    lp <= 1'b0;
    pre <= PRE_DIV16;
    refresh(REFRESH_FIRST, REFRESH_SECOND);
    chk(status, TOUT_0);
    pulses(15);
    chk(status, TOUT_0);
    pulses(1);
    chk(status, 16'h03FE);
    wopen <= 2'h0;
    clear_seen();
    refresh(REFRESH_FIRST, REFRESH_SECOND);
    chk(seen, 4'h6);
    chk(counting, 1'b0);
    wopen <= 2'h3;
    pre <= PRE_DIV1;
    act <= 1'b0;
    refresh(REFRESH_FIRST, REFRESH_SECOND);
    chk(counting, 1'b1);
    clear_seen();
    pulses(1024);
    chk(seen, 4'h9);
    chk(counting, 1'b0);
    tout  <= 2'h3;
    wopen <= 2'h0;
    refresh(REFRESH_FIRST, REFRESH_SECOND);
    chk(status, TOUT_3);
    clear_seen();
    refresh(REFRESH_FIRST, REFRESH_SECOND);
    chk(seen, 4'h5);
    chk(counting, 1'b0);
    auto_start <= 1'b1;
    do_reset();
    settle();
    chk(status, TOUT_0);
    chk(counting, 1'b1);
    clear_seen();
    pulses(1024);
    chk(seen, 4'hA);
    chk(counting, 1'b1);
    print_verdict();
  end
endmodule : tb
